// [rtl/pmc_device.sv]
`timescale 1ns/10ps
`default_nettype none
module pmc_device
   import pmc_pkg::*;
#(
   parameter int unsigned STARTUP_CYC = STARTUP_WAIT_CYC,
   parameter int unsigned IDLE_CYC    = IDLE_TIMEOUT_CYC
)
(
   input  wire logic ref_clk,
   input  wire logic srst,
   pmc_if.dev        lnk,
   input  wire logic is_base,
   input  wire logic wake_pin_req,
   input  wire logic chain_wake_tone,
   input  wire logic chain_resume_tone,
   input  wire logic thermal_shutdown,
   input  wire logic idle_timeout_en,
   input  wire logic valid_frame,
   input  wire logic heartbeat_en,
   output logic      defaults_load,
   output logic      wake_forward,
   output logic      resume_forward,
   output logic      heartbeat_run,
   output logic      en_limit_comparators,
   output logic      en_balancing,
   output logic      en_shutdown_detect,
   output logic      en_fault_tone,
   output logic      en_resume_detect,
   output logic      en_wake_detect,
   output logic      en_gpio_fault,
   output logic      en_nvm_crc,
   output logic      en_comms,
   output logic      en_adc,
   output logic      en_spi_master,
   output logic      en_comm_timeout,
   output logic      ready_o,
   output logic [1:0] state_o
);
   pmc_state_t state_r;
   pmc_state_t state_nxt;
   logic       flag_r;
   logic       flag_nxt;
   logic       dflt_r;
   logic       dflt_nxt;
   logic       wfwd_r;
   logic       wfwd_nxt;
   logic       rfwd_r;
   logic       rfwd_nxt;
   logic       hb_r;
   logic       hb_nxt;
   logic       starting_r;
   logic       starting_nxt;
   logic       wake_any;
   logic       resume_any;
   logic       idle_expired;
   logic       startup_done;
   logic       wake_event;
   logic       act_r;
   logic       act_nxt;
   logic       rdy_r;
   logic       rdy_nxt;
   logic       flt_n_r;
   logic       flt_n_nxt;
   logic       awake_r;
   logic       awake_nxt;

   // Base devices listen to the pin and serial line; stack devices to the chain.
   assign wake_any   = is_base ? (wake_pin_req | lnk.wake_req) : chain_wake_tone;
   assign resume_any = is_base ? lnk.resume_req : chain_resume_tone;

   pmc_timer #(.LIMIT(IDLE_CYC)) u_idle
   (
      .ref_clk (ref_clk),
      .srst    (srst),
      .restart (valid_frame),
      .run     (idle_timeout_en && state_r == PMC_ACTIVE),
      .expired (idle_expired)
   );

   pmc_timer #(.LIMIT(STARTUP_CYC)) u_start
   (
      .ref_clk (ref_clk),
      .srst    (srst),
      .restart (wake_event),
      .run     (starting_r),
      .expired (startup_done)
   );

   always_comb
   begin
      state_nxt    = state_r;
      flag_nxt     = flag_r;
      dflt_nxt     = 1'b0;
      wfwd_nxt     = 1'b0;
      rfwd_nxt     = 1'b0;
      starting_nxt = starting_r;
      wake_event   = 1'b0;
      case (state_r)
         PMC_SHUTDOWN:
         begin
            if (wake_any)
            begin
               state_nxt  = PMC_ACTIVE;
               dflt_nxt   = 1'b1;
               flag_nxt   = 1'b1;
               wake_event = 1'b1;
            end
         end
         PMC_SLEEP:
         begin
            if (wake_any)
            begin
               state_nxt  = PMC_ACTIVE;
               dflt_nxt   = 1'b1;
               flag_nxt   = 1'b1;
               wake_event = 1'b1;
            end
            else if (resume_any)
            begin
               state_nxt = PMC_ACTIVE;
            end
         end
         PMC_ACTIVE:
         begin
            if (thermal_shutdown || lnk.shutdown_command || idle_expired)
            begin
               state_nxt = PMC_SHUTDOWN;
            end
            else if (wake_any)
            begin
               dflt_nxt   = 1'b1;
               wfwd_nxt   = 1'b1;
               flag_nxt   = 1'b1;
               wake_event = 1'b1;
            end
            else if (lnk.sleep_command)
            begin
               state_nxt = PMC_SLEEP;
            end
            else if (resume_any)
            begin
               rfwd_nxt = 1'b1;
            end
         end
         default:
         begin
            state_nxt = PMC_SHUTDOWN;
         end
      endcase
      // A flag set in the same cycle as its clear wins.
      if (lnk.reset_flag_clear && state_r == PMC_ACTIVE && !wake_event)
      begin
         flag_nxt = 1'b0;
      end
      if (wake_event)
      begin
         starting_nxt = 1'b1;
      end
      else if (startup_done || state_nxt != PMC_ACTIVE)
      begin
         starting_nxt = 1'b0;
      end
      hb_nxt = heartbeat_en && !flag_nxt && state_nxt == PMC_ACTIVE;
      // Mode outputs are loaded from the next state so they switch with the state itself.
      act_nxt   = (state_nxt == PMC_ACTIVE);
      rdy_nxt   = act_nxt && !starting_nxt;
      flt_n_nxt = !flag_nxt;
      awake_nxt = (state_nxt != PMC_SHUTDOWN);
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state_r    <= PMC_SHUTDOWN;
         flag_r     <= RESET_FLAG_RST;
         dflt_r     <= 1'b1;
         wfwd_r     <= 1'b0;
         rfwd_r     <= 1'b0;
         hb_r       <= 1'b0;
         starting_r <= 1'b0;
         act_r      <= 1'b0;
         rdy_r      <= 1'b0;
         flt_n_r    <= ~RESET_FLAG_RST;
         awake_r    <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         flag_r     <= flag_nxt;
         dflt_r     <= dflt_nxt;
         wfwd_r     <= wfwd_nxt;
         rfwd_r     <= rfwd_nxt;
         hb_r       <= hb_nxt;
         starting_r <= starting_nxt;
         act_r      <= act_nxt;
         rdy_r      <= rdy_nxt;
         flt_n_r    <= flt_n_nxt;
         awake_r    <= awake_nxt;
      end
   end

   assign lnk.reset_occurred_flag = flag_r;
   assign lnk.fault_output_n      = flt_n_r;
   assign lnk.active              = act_r;
   assign lnk.ready               = rdy_r;
   assign ready_o                 = lnk.ready;
   assign state_o                 = state_r;
   assign defaults_load           = dflt_r;
   assign wake_forward            = wfwd_r;
   assign resume_forward          = rfwd_r;
   assign heartbeat_run           = hb_r;

   // Function enables other than en_wake_detect, which is tied high, come from registers that track the state on the same edge.
   assign en_limit_comparators = awake_r;
   assign en_balancing         = awake_r;
   assign en_shutdown_detect   = awake_r;
   assign en_fault_tone        = awake_r;
   assign en_resume_detect     = awake_r;
   assign en_wake_detect       = 1'b1;
   assign en_gpio_fault        = awake_r;
   assign en_nvm_crc           = awake_r;
   assign en_comms             = act_r;
   assign en_adc               = act_r;
   assign en_spi_master        = act_r;
   assign en_comm_timeout      = act_r;
endmodule : pmc_device
`default_nettype wire

// [rtl/pmc_host.sv]
`timescale 1ns/10ps
`default_nettype none
module pmc_host
   import pmc_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic srst,
   pmc_if.host       lnk,
   input  wire logic req_wake,
   input  wire logic req_resume,
   input  wire logic req_sleep,
   input  wire logic req_shutdown,
   input  wire logic protections_on,
   output logic      dev_usable,
   output logic      dev_reset_seen
);
   logic wake_r;
   logic wake_nxt;
   logic res_r;
   logic res_nxt;
   logic slp_r;
   logic slp_nxt;
   logic sd_r;
   logic sd_nxt;
   logic clr_r;
   logic clr_nxt;
   logic use_r;
   logic use_nxt;
   logic seen_r;
   logic seen_nxt;

   always_comb
   begin
      wake_nxt = req_wake;
      res_nxt  = req_resume;
      // Sleep only once protections are running in ACTIVE.
      slp_nxt  = req_sleep && lnk.active && protections_on && !slp_r;
      sd_nxt   = req_shutdown && !sd_r;
      // Clear the reset flag only once start-up has completed.
      clr_nxt  = lnk.reset_occurred_flag && lnk.ready && !clr_r;
      use_nxt  = lnk.ready && !lnk.reset_occurred_flag;
      seen_nxt = lnk.reset_occurred_flag;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         wake_r <= 1'b0;
         res_r  <= 1'b0;
         slp_r  <= 1'b0;
         sd_r   <= 1'b0;
         clr_r  <= 1'b0;
         use_r  <= 1'b0;
         seen_r <= 1'b0;
      end
      else
      begin
         wake_r <= wake_nxt;
         res_r  <= res_nxt;
         slp_r  <= slp_nxt;
         sd_r   <= sd_nxt;
         clr_r  <= clr_nxt;
         use_r  <= use_nxt;
         seen_r <= seen_nxt;
      end
   end

   assign lnk.wake_req         = wake_r;
   assign lnk.resume_req       = res_r;
   assign lnk.sleep_command    = slp_r;
   assign lnk.shutdown_command = sd_r;
   assign lnk.reset_flag_clear = clr_r;
   assign dev_usable           = use_r;
   assign dev_reset_seen       = seen_r;
endmodule : pmc_host
`default_nettype wire

// [rtl/pmc_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface pmc_if;
   logic wake_req;
   logic resume_req;
   logic sleep_command;
   logic shutdown_command;
   logic reset_flag_clear;
   logic reset_occurred_flag;
   logic fault_output_n;
   logic active;
   logic ready;

   modport dev
   (
      input  wake_req,
      input  resume_req,
      input  sleep_command,
      input  shutdown_command,
      input  reset_flag_clear,
      output reset_occurred_flag,
      output fault_output_n,
      output active,
      output ready
   );

   modport host
   (
      output wake_req,
      output resume_req,
      output sleep_command,
      output shutdown_command,
      output reset_flag_clear,
      input  reset_occurred_flag,
      input  fault_output_n,
      input  active,
      input  ready
   );
endinterface : pmc_if
`default_nettype wire

// [rtl/pmc_pkg.sv]
package pmc_pkg;
   localparam int unsigned CLK_HZ                = 25000000;
   localparam int unsigned STARTUP_WAIT_US       = 1000;
   localparam int unsigned STARTUP_WAIT_CYC      = (STARTUP_WAIT_US * (CLK_HZ / 1000000));
   localparam int unsigned IDLE_TIMEOUT_CYC      = 250000;
   localparam int unsigned CNT_W                 = 32;
   localparam logic        RESET_FLAG_RST        = 1'b1;

   typedef enum logic [1:0]
   {
      PMC_SHUTDOWN,
      PMC_SLEEP,
      PMC_ACTIVE
   } pmc_state_t;
endpackage : pmc_pkg

// [rtl/pmc_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module pmc_timer
   import pmc_pkg::*;
#(
   parameter int unsigned LIMIT = 16
)
(
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic restart,
   input  wire logic run,
   output logic      expired
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             exp_r;
   logic             exp_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      exp_nxt = 1'b0;
      if (restart || !run)
      begin
         cnt_nxt = '0;
      end
      else if (cnt_r >= CNT_W'(LIMIT - 1))
      begin
         exp_nxt = 1'b1;
         cnt_nxt = '0;
      end
      else
      begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cnt_r <= '0;
         exp_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign expired = exp_r;
endmodule : pmc_timer
`default_nettype wire

// [verif/pmc_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module pmc_monitor
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wake_req,
   input wire logic resume_req,
   input wire logic sleep_command,
   input wire logic shutdown_command,
   input wire logic reset_flag_clear,
   input wire logic reset_occurred_flag,
   input wire logic fault_output_n,
   input wire logic active,
   input wire logic ready,
   input wire logic side_wake
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_fault; fault_output_n == !reset_occurred_flag; endproperty
   a_fault: assert property (p_fault) else $error("fault output disagrees with flag");
   property p_wake; wake_req && !shutdown_command |=> active && reset_occurred_flag && !ready; endproperty
   a_wake: assert property (p_wake) else $error("wake did not give active with flag");
   property p_sleep; active && sleep_command && !shutdown_command && !wake_req |=> !active; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep command did not leave active");
   property p_shut; active && shutdown_command |=> !active; endproperty
   a_shut: assert property (p_shut) else $error("shutdown command did not leave active");
   property p_clear; active && reset_flag_clear && !wake_req |=> !reset_occurred_flag; endproperty
   a_clear: assert property (p_clear) else $error("flag clear ignored in active");
   property p_norm; !active && reset_flag_clear && !wake_req && reset_occurred_flag |=> reset_occurred_flag;
   endproperty
   a_norm: assert property (p_norm) else $error("flag cleared outside active");
   property p_resume; active && resume_req && !wake_req && !sleep_command && !shutdown_command && !reset_flag_clear
      |=> active && $stable(reset_occurred_flag); endproperty
   a_resume: assert property (p_resume) else $error("resume in active changed state");
   property p_ready; ready |-> active; endproperty
   a_ready: assert property (p_ready) else $error("ready outside active");
   property p_stay; !active && !wake_req && !resume_req && !side_wake |=> !active; endproperty
   a_stay: assert property (p_stay) else $error("left low power on its own");
   c_wake: cover property (!active ##1 active);
   c_clear: cover property (reset_occurred_flag ##1 !reset_occurred_flag);
   c_sleep: cover property (active && sleep_command);
endmodule : pmc_monitor
`default_nettype wire

// [verif/power_mode_controller_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
`define PULSE(s) begin @(posedge ref_clk); s <= 1'b1; @(posedge ref_clk); s <= 1'b0; end
module power_mode_controller_bench
   import pmc_pkg::*;
();
   logic ref_clk = 0, srst = 1, req_wake = 0, req_resume = 0, req_sleep = 0, req_shutdown = 0, protections_on = 0;
   logic is_base = 1, wake_pin_req = 0, chain_wake_tone = 0, chain_resume_tone = 0, thermal_shutdown = 0;
   logic idle_timeout_en = 0, valid_frame = 1, heartbeat_en = 1;
   logic defaults_load, wake_forward, resume_forward, heartbeat_run, en_limit_comparators, en_balancing;
   logic en_wake_detect, en_comms, en_adc;
   logic en_shutdown_detect, en_fault_tone, en_resume_detect, en_gpio_fault, en_nvm_crc, en_spi_master;
   logic en_comm_timeout, ready_o, dev_usable, dev_reset_seen;
   logic [1:0] state_o;
   int failures = 0, n_tests = 0, n_def = 0, n_wk = 0, n_res = 0, d, w;
   pmc_if lnk ();
   pmc_device #(.STARTUP_CYC(8), .IDLE_CYC(8)) pmc_device_i (.ref_clk(ref_clk), .srst(srst), .lnk(lnk),
      .is_base(is_base), .wake_pin_req(wake_pin_req), .chain_wake_tone(chain_wake_tone),
      .chain_resume_tone(chain_resume_tone), .thermal_shutdown(thermal_shutdown), .idle_timeout_en(idle_timeout_en),
      .valid_frame(valid_frame), .heartbeat_en(heartbeat_en), .defaults_load(defaults_load),
      .wake_forward(wake_forward), .resume_forward(resume_forward), .heartbeat_run(heartbeat_run),
      .en_limit_comparators(en_limit_comparators), .en_balancing(en_balancing),
      .en_shutdown_detect(en_shutdown_detect), .en_fault_tone(en_fault_tone), .en_resume_detect(en_resume_detect),
      .en_wake_detect(en_wake_detect), .en_gpio_fault(en_gpio_fault), .en_nvm_crc(en_nvm_crc),
      .en_comms(en_comms), .en_adc(en_adc), .en_spi_master(en_spi_master), .en_comm_timeout(en_comm_timeout),
      .ready_o(ready_o), .state_o(state_o));
   pmc_host pmc_host_i (.ref_clk(ref_clk), .srst(srst), .lnk(lnk), .req_wake(req_wake), .req_resume(req_resume),
      .req_sleep(req_sleep), .req_shutdown(req_shutdown), .protections_on(protections_on), .dev_usable(dev_usable),
      .dev_reset_seen(dev_reset_seen));
   pmc_monitor pmc_monitor_i (.ref_clk(ref_clk), .srst(srst), .wake_req(lnk.wake_req), .resume_req(lnk.resume_req),
      .sleep_command(lnk.sleep_command), .shutdown_command(lnk.shutdown_command),
      .reset_flag_clear(lnk.reset_flag_clear), .reset_occurred_flag(lnk.reset_occurred_flag),
      .fault_output_n(lnk.fault_output_n), .active(lnk.active), .ready(lnk.ready),
      .side_wake(wake_pin_req | chain_wake_tone | chain_resume_tone));

   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      n_def += (defaults_load === 1'b1);
      n_wk  += (wake_forward === 1'b1);
      n_res += (resume_forward === 1'b1);
   end

   task automatic complete_run();
      if (failures == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   task automatic wait_st(input logic [1:0] e);
      int k;
      k = 0;
      while (state_o !== e && k < 100)
      begin
         @(posedge ref_clk);
         k++;
      end
      #1 `CHK("state", e, state_o)
   endtask : wait_st

   // The host end clears the flag by itself once the device reports ready.
   task automatic wait_clear();
      int k;
      k = 0;
      while (lnk.reset_occurred_flag !== 1'b0 && k < 200)
      begin
         @(posedge ref_clk);
         k++;
      end
      #1 `CHK("flag", 1'b0, lnk.reset_occurred_flag)
      `CHK("fault_n", 1'b1, lnk.fault_output_n)
      `CHK("heartbeat", 1'b1, heartbeat_run)
      `CHK("ready", 1'b1, ready_o)
      `CHK("usable", 1'b1, dev_usable)
      `CHK("seen", 1'b0, dev_reset_seen)
   endtask : wait_clear

   task automatic t_chain();
      @(posedge ref_clk);
      is_base <= 1'b0;
      d = n_def;
      w = n_res;
      `PULSE(chain_resume_tone)
      repeat (3) @(posedge ref_clk);
      `CHK("res_fwd", w + 1, n_res)
      `CHK("defaults", d, n_def)
      `CHK("flag", 1'b0, lnk.reset_occurred_flag)
      w = n_wk;
      `PULSE(chain_wake_tone)
      repeat (3) @(posedge ref_clk);
      `CHK("wake_fwd", w + 1, n_wk)
      `CHK("defaults", d + 1, n_def)
      `CHK("flag", 1'b1, lnk.reset_occurred_flag)
      `CHK("seen", 1'b1, dev_reset_seen)
      wait_clear();
      @(posedge ref_clk);
      is_base <= 1'b1;
   endtask : t_chain

   task automatic t_sleep();
      @(posedge ref_clk);
      protections_on <= 1'b1;
      w = n_res;
      `PULSE(req_resume)
      repeat (3) @(posedge ref_clk);
      `CHK("res_fwd", w + 1, n_res)
      `PULSE(req_sleep)
      wait_st(PMC_SLEEP);
      `CHK("comms", 1'b0, en_comms)
      `CHK("adc", 1'b0, en_adc)
      `CHK("balance", 1'b1, en_balancing)
      `CHK("limits", 1'b1, en_limit_comparators)
      `CHK("sd_det", 1'b1, en_shutdown_detect)
      `CHK("tone", 1'b1, en_fault_tone)
      `CHK("res_det", 1'b1, en_resume_detect)
      `CHK("gpio", 1'b1, en_gpio_fault)
      `CHK("nvm", 1'b1, en_nvm_crc)
      `CHK("spi", 1'b0, en_spi_master)
      `CHK("comm_to", 1'b0, en_comm_timeout)
      d = n_def;
      `PULSE(req_resume)
      wait_st(PMC_ACTIVE);
      `CHK("defaults", d, n_def)
      `CHK("flag", 1'b0, lnk.reset_occurred_flag)
      `PULSE(req_sleep)
      wait_st(PMC_SLEEP);
      `PULSE(wake_pin_req)
      wait_st(PMC_ACTIVE);
      `CHK("defaults", d + 1, n_def)
      wait_clear();
   endtask : t_sleep

   task automatic t_shut();
      @(posedge ref_clk);
      idle_timeout_en <= 1'b1;
      valid_frame <= 1'b0;
      wait_st(PMC_SHUTDOWN);
      `CHK("wake_det", 1'b1, en_wake_detect)
      `CHK("balance", 1'b0, en_balancing)
      @(posedge ref_clk);
      idle_timeout_en <= 1'b0;
      valid_frame <= 1'b1;
      `PULSE(wake_pin_req)
      wait_st(PMC_ACTIVE);
      wait_clear();
      `PULSE(thermal_shutdown)
      wait_st(PMC_SHUTDOWN);
      `PULSE(req_resume)
      repeat (20) @(posedge ref_clk);
      `CHK("state", PMC_SHUTDOWN, state_o)
      `PULSE(wake_pin_req)
      wait_st(PMC_ACTIVE);
      // Leave ACTIVE just as the host end raises its flag clear, so the clear arrives outside ACTIVE.
      @(posedge lnk.ready);
      thermal_shutdown <= 1'b1;
      @(posedge ref_clk);
      thermal_shutdown <= 1'b0;
      wait_st(PMC_SHUTDOWN);
      repeat (3) @(posedge ref_clk);
      `CHK("flag", 1'b1, lnk.reset_occurred_flag)
      `PULSE(wake_pin_req)
      wait_st(PMC_ACTIVE);
      wait_clear();
      `PULSE(req_shutdown)
      wait_st(PMC_SHUTDOWN);
   endtask : t_shut

   initial
   begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      complete_run();
   end

   initial
   begin
      repeat (16) @(posedge ref_clk);
      srst <= 1'b0;
      #1 `CHK("state", PMC_SHUTDOWN, state_o)
      `CHK("flag", 1'b1, lnk.reset_occurred_flag)
      `PULSE(req_wake)
      wait_st(PMC_ACTIVE);
      wait_clear();
      t_chain();
      t_sleep();
      t_shut();
      complete_run();
   end
endmodule : power_mode_controller_bench
`default_nettype wire
